// *** hdl/host_cmd_decoder.sv ***
// Host command decoder with crash dump and command error packet builder
//
// Notes on behaviour
// - Header is 16-bit identifier then 16-bit length
// - Bootloader accepts 0x0001-0x0006 and 0x0017 only
// - Framework accepts 0x0007-0x0012 and 0x0015
// - Framework decodes 0x0100-0x0FFF as parameter writes
// - Framework decodes 0x1000-0x1FFF as parameter reads
// - Only listed commands expect a status packet
// - Malformed or invalid command gets error packet
// - Crash request streams stored reset record out
// - Dump opens with code 0x0003 and length
// - Bytes 0x04-0x83 carry saved core context
// - Byte 0x84 is the crash validity flag
// - Byte 0x85 holds four record flags
// - Stack size and stack start address follow
// - Five exception words at 0x8C-0x9F
// - Diagnostic word then interrupt cause word
// - Five host register copies at 0xA8-0xAC
// - Byte 0xAD encodes the reset reason
// - Byte 0xAF encodes the exception cause
// - Protection fault cause, then user stack pointer
// - Stack CRC and record CRC fields
`timescale 1ns/100ps
`default_nettype none
module host_cmd_decoder
  import host_cmd_pkg::*;
(
  // Clock and reset
  input  wire logic                CLK,
  input  wire logic                RST,
  // Boot stage
  input  wire logic                FRAMEWORK_MODE,
  // Command byte stream from host interface
  input  wire logic                CMD_VALID,
  input  wire logic [7:0]          CMD_DATA,
  output logic                     CMD_READY,
  // Decoded command to firmware
  output logic                     DEC_VALID,
  output logic      [15:0]         DEC_ID,
  output logic      [15:0]         DEC_LENGTH,
  output logic      [2:0]          DEC_CLASS,
  output logic                     DEC_STATUS_EXPECTED,
  // Payload bytes of accepted commands
  output logic                     PAY_VALID,
  output logic      [7:0]          PAY_DATA,
  // Crash record write port from the core
  input  wire logic                DUMP_WE,
  input  wire logic [DUMP_AW-1:0]  DUMP_WADDR,
  input  wire logic [31:0]         DUMP_WDATA,
  // Status channel
  output logic                     STAT_VALID,
  output logic      [7:0]          STAT_DATA,
  input  wire logic                STAT_READY
);
  typedef enum logic [2:0] {
    S_ID0,
    S_ID1,
    S_LEN0,
    S_LEN1,
    S_PAYLOAD,
    S_STACK_CRC,
    S_DUMP,
    S_ERROR
  } state_t;

  state_t      state;
  logic [15:0] cmd_id;
  logic [7:0]  len_lo;
  logic [15:0] remain;
  logic        bad;
  logic        is_crash;
  logic [8:0]  idx;
  logic [31:0] crc;
  logic [31:0] stack_crc;
  logic [31:0] dump_mem [DUMP_WORDS];

  logic        in_take;
  logic [15:0] full_len;
  cmd_class_t  cls;
  logic        malformed;
  logic [15:0] pay_count;
  logic        fifo_in_valid;
  logic        fifo_in_ready;
  logic [7:0]  fifo_in_data;
  logic        push;
  logic [7:0]  flags;
  logic [8:0]  stk_size;
  logic [8:0]  stack_len;
  logic [8:0]  total_len;
  logic [15:0] dump_len;
  logic [7:0]  dump_byte;
  logic [7:0]  err_byte;

  function automatic cmd_class_t decode(input logic [15:0] id, input logic fw);
    cmd_class_t c;
    c = CLS_INVALID;
    if (!fw) begin
      if (id == CMD_CRASH_DUMP) begin
        c = CLS_CRASH;
      end else if ((id >= CMD_RAM_UPLOAD && id <= CMD_FLASH_BOOT) ||
                   id == CMD_SPEED_RAISE) begin
        c = CLS_BOOT;
      end
    end else begin
      if ((id >= CMD_FW_FIRST && id <= CMD_FW_LAST) || id == CMD_FIFO_FORMAT) begin
        c = CLS_FW;
      end else if (id >= PARAM_WR_FIRST && id <= PARAM_WR_LAST) begin
        c = CLS_PARAM_WR;
      end else if (id >= PARAM_RD_FIRST && id <= PARAM_RD_LAST) begin
        c = CLS_PARAM_RD;
      end
    end
    return c;
  endfunction

  function automatic logic expects_status(input logic [15:0] id, input cmd_class_t c);
    logic e;
    e = (c == CLS_PARAM_WR) || (c == CLS_PARAM_RD);
    if (id == CMD_CRASH_DUMP || id == CMD_FLASH_ERASE || id == CMD_FLASH_WRITE ||
        id == CMD_INJECT_MODE || id == CMD_PASS_THROUGH || id == CMD_SELF_TEST ||
        id == CMD_OFFSET_COMP || id == CMD_TEST_RESUME || id == CMD_TEST_START ||
        id == CMD_SPEED_RAISE) begin
      e = 1'b1;
    end
    return e;
  endfunction

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic [7:0] rd_byte(input logic [8:0] a);
    logic [31:0] w;
    w = dump_mem[a[8:2]];
    return w[{a[1:0], 3'b000} +: 8];
  endfunction

  // Header and length decode
  assign in_take   = CMD_VALID && CMD_READY;
  assign full_len  = {CMD_DATA, len_lo};
  assign cls       = decode(cmd_id, FRAMEWORK_MODE);
  assign malformed = (cls == CLS_CRASH) && (full_len != 16'h0000);
  assign pay_count = (cmd_id == CMD_SPEED_RAISE) ? SPEED_PAYLOAD : full_len;
  assign CMD_READY = (state == S_ID0) || (state == S_ID1) || (state == S_LEN0) ||
                     (state == S_LEN1) || (state == S_PAYLOAD);

  // Dump geometry from the stored record
  assign flags     = rd_byte(OFS_FLAGS);
  assign stk_size  = (rd_byte(OFS_STK_SIZE + 9'h001) != 8'h00) ? STACK_MAX :
                     ((rd_byte(OFS_STK_SIZE) == 8'h00) ? 9'h000 :
                      {1'b0, rd_byte(OFS_STK_SIZE)});
  assign stack_len = flags[FLAG_STK_INCL] ? stk_size : 9'h000;
  assign total_len = OFS_STACK + stack_len;
  assign dump_len  = {7'h00, total_len - OFS_CONTEXT};

  // Crash dump byte at the current offset
  always_comb begin
    if (idx < OFS_LENGTH) begin
      dump_byte = CRASH_STATUS_CODE[{idx[0], 3'b000} +: 8];
    end else if (idx < OFS_CONTEXT) begin
      dump_byte = dump_len[{idx[0], 3'b000} +: 8];
    end else if (idx >= OFS_RSVD_LO && idx <= OFS_RSVD_HI) begin
      dump_byte = 8'h00;
    end else if (idx >= OFS_STACK_CRC && idx < OFS_CRC) begin
      dump_byte = ~stack_crc[{idx[1:0], 3'b000} +: 8];
    end else if (idx >= OFS_CRC && idx < OFS_STACK) begin
      dump_byte = ~crc[{idx[1:0], 3'b000} +: 8];
    end else begin
      // Saved record fields and stack dump, little-endian
      dump_byte = rd_byte(idx);
    end
  end

  // Command error packet bytes
  always_comb begin
    unique case (idx[2:0])
      3'h0:    err_byte = CMD_ERROR_STATUS[7:0];
      3'h1:    err_byte = CMD_ERROR_STATUS[15:8];
      3'h2:    err_byte = CMD_ERROR_LENGTH[7:0];
      3'h3:    err_byte = CMD_ERROR_LENGTH[15:8];
      3'h4:    err_byte = cmd_id[7:0];
      3'h5:    err_byte = cmd_id[15:8];
      3'h6:    err_byte = CMD_ERROR_VALUE;
      3'h7:    err_byte = 8'h00;
    endcase
  end

  assign fifo_in_valid = (state == S_DUMP) || (state == S_ERROR);
  assign fifo_in_data  = (state == S_ERROR) ? err_byte : dump_byte;
  assign push          = fifo_in_valid && fifo_in_ready;

  // Record storage written by the core
  always_ff @(posedge CLK) begin
    if (DUMP_WE) begin
      dump_mem[DUMP_WADDR] <= DUMP_WDATA;
    end
  end

  // Command sequencing
  always_ff @(posedge CLK) begin
    if (RST) begin
      state    <= S_ID0;
      cmd_id   <= 16'h0000;
      len_lo   <= 8'h00;
      remain   <= 16'h0000;
      bad      <= 1'b0;
      is_crash <= 1'b0;
      idx      <= 9'h000;
    end else begin
      unique case (state)
        S_ID0: begin
          if (in_take) begin
            cmd_id[7:0] <= CMD_DATA;
            state       <= S_ID1;
          end
        end
        S_ID1: begin
          if (in_take) begin
            cmd_id[15:8] <= CMD_DATA;
            state        <= S_LEN0;
          end
        end
        S_LEN0: begin
          if (in_take) begin
            len_lo <= CMD_DATA;
            state  <= S_LEN1;
          end
        end
        S_LEN1: begin
          if (in_take) begin
            bad      <= (cls == CLS_INVALID) || malformed;
            is_crash <= (cls == CLS_CRASH);
            remain   <= pay_count;
            idx      <= 9'h000;
            if (pay_count != 16'h0000) begin
              state <= S_PAYLOAD;
            end else if ((cls == CLS_INVALID) || malformed) begin
              state <= S_ERROR;
            end else if (cls == CLS_CRASH) begin
              state <= S_STACK_CRC;
            end else begin
              state <= S_ID0;
            end
          end
        end
        S_PAYLOAD: begin
          if (in_take) begin
            remain <= remain - 16'h0001;
            if (remain == 16'h0001) begin
              if (bad) begin
                state <= S_ERROR;
              end else if (is_crash) begin
                state <= S_STACK_CRC;
              end else begin
                state <= S_ID0;
              end
            end
          end
        end
        S_STACK_CRC: begin
          if (idx == stack_len) begin
            idx   <= 9'h000;
            state <= S_DUMP;
          end else begin
            idx <= idx + 9'h001;
          end
        end
        S_DUMP: begin
          if (push) begin
            idx <= idx + 9'h001;
            if (idx == total_len - 9'h001) begin
              state <= S_ID0;
            end
          end
        end
        S_ERROR: begin
          if (push) begin
            idx <= idx + 9'h001;
            if (idx == ERROR_LAST_BYTE) begin
              state <= S_ID0;
            end
          end
        end
      endcase
    end
  end

  // CRC over stack dump, then over bytes 0x04-0xC7
  always_ff @(posedge CLK) begin
    if (RST) begin
      stack_crc <= CRC_INIT;
      crc       <= CRC_INIT;
    end else if (state == S_LEN1) begin
      stack_crc <= CRC_INIT;
      crc       <= CRC_INIT;
    end else if (state == S_STACK_CRC && idx != stack_len) begin
      stack_crc <= crc_byte(stack_crc, rd_byte(OFS_STACK + idx));
    end else if (state == S_DUMP && push && idx >= OFS_CONTEXT && idx <= OFS_CRC_LAST) begin
      crc <= crc_byte(crc, dump_byte);
    end
  end

  // Decoded command event
  always_ff @(posedge CLK) begin
    if (RST) begin
      DEC_VALID           <= 1'b0;
      DEC_ID              <= 16'h0000;
      DEC_LENGTH          <= 16'h0000;
      DEC_CLASS           <= 3'h0;
      DEC_STATUS_EXPECTED <= 1'b0;
    end else begin
      DEC_VALID <= in_take && (state == S_LEN1) && (cls != CLS_INVALID) && !malformed;
      if (in_take && state == S_LEN1) begin
        DEC_ID              <= cmd_id;
        DEC_LENGTH          <= full_len;
        DEC_CLASS           <= cls;
        DEC_STATUS_EXPECTED <= expects_status(cmd_id, cls);
      end
    end
  end

  // Payload forwarding for accepted commands
  always_ff @(posedge CLK) begin
    if (RST) begin
      PAY_VALID <= 1'b0;
      PAY_DATA  <= 8'h00;
    end else begin
      PAY_VALID <= in_take && (state == S_PAYLOAD) && !bad;
      if (in_take && state == S_PAYLOAD) begin
        PAY_DATA <= CMD_DATA;
      end
    end
  end

  stream_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_status_fifo (
    .clk       (CLK),
    .rst       (RST),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (STAT_VALID),
    .out_ready (STAT_READY),
    .out_data  (STAT_DATA)
  );
endmodule
`default_nettype wire

// *** common/host_cmd_pkg.sv ***
// Constants and types for the host command decoder and crash dump builder
package host_cmd_pkg;
  // Command identifiers
  localparam logic [15:0] CMD_CRASH_DUMP   = 16'h0001;
  localparam logic [15:0] CMD_RAM_UPLOAD   = 16'h0002;
  localparam logic [15:0] CMD_FLASH_BOOT   = 16'h0006;
  localparam logic [15:0] CMD_FLASH_ERASE  = 16'h0004;
  localparam logic [15:0] CMD_FLASH_WRITE  = 16'h0005;
  localparam logic [15:0] CMD_SPEED_RAISE  = 16'h0017;
  localparam logic [15:0] CMD_FW_FIRST     = 16'h0007;
  localparam logic [15:0] CMD_FW_LAST      = 16'h0012;
  localparam logic [15:0] CMD_FIFO_FORMAT  = 16'h0015;
  localparam logic [15:0] CMD_INJECT_MODE  = 16'h0007;
  localparam logic [15:0] CMD_PASS_THROUGH = 16'h000A;
  localparam logic [15:0] CMD_SELF_TEST    = 16'h000B;
  localparam logic [15:0] CMD_OFFSET_COMP  = 16'h000C;
  localparam logic [15:0] CMD_TEST_RESUME  = 16'h0011;
  localparam logic [15:0] CMD_TEST_START   = 16'h0012;
  localparam logic [15:0] PARAM_WR_FIRST   = 16'h0100;
  localparam logic [15:0] PARAM_WR_LAST    = 16'h0FFF;
  localparam logic [15:0] PARAM_RD_FIRST   = 16'h1000;
  localparam logic [15:0] PARAM_RD_LAST    = 16'h1FFF;
  // Speed raise carries a fixed payload after its length bytes
  localparam logic [15:0] SPEED_PAYLOAD    = 16'h0004;

  // Status packets
  localparam logic [15:0] CRASH_STATUS_CODE = 16'h0003;
  localparam logic [15:0] CMD_ERROR_STATUS  = 16'h0010;
  localparam logic [15:0] CMD_ERROR_LENGTH  = 16'h0004;
  localparam logic [7:0]  CMD_ERROR_VALUE   = 8'hC0;
  localparam logic [8:0]  ERROR_LAST_BYTE   = 9'h007;

  // Crash dump byte offsets
  localparam logic [8:0] OFS_LENGTH    = 9'h002;
  localparam logic [8:0] OFS_CONTEXT   = 9'h004;
  localparam logic [8:0] OFS_FLAGS     = 9'h085;
  localparam logic [8:0] OFS_STK_SIZE  = 9'h086;
  localparam logic [8:0] OFS_RSVD_LO   = 9'h0B8;
  localparam logic [8:0] OFS_RSVD_HI   = 9'h0C3;
  localparam logic [8:0] OFS_STACK_CRC = 9'h0C4;
  localparam logic [8:0] OFS_CRC       = 9'h0C8;
  localparam logic [8:0] OFS_CRC_LAST  = 9'h0C7;
  localparam logic [8:0] OFS_STACK     = 9'h0CC;
  localparam int         FLAG_STK_INCL = 2;
  localparam logic [8:0] STACK_MAX     = 9'h100;

  // Record storage
  localparam int DUMP_WORDS = 128;
  localparam int DUMP_AW    = 7;

  // CRC-32, reflected form
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;

  // Status FIFO
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [2:0] {
    CLS_INVALID,
    CLS_CRASH,
    CLS_BOOT,
    CLS_FW,
    CLS_PARAM_WR,
    CLS_PARAM_RD
  } cmd_class_t;
endpackage

// *** hdl/stream_fifo.sv ***
// Valid/ready byte FIFO for the status channel
`timescale 1ns/100ps
`default_nettype none
module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
  assign out_valid = wr_ptr != rd_ptr;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
    end else if (push) begin
      wr_ptr <= wr_ptr + (AW+1)'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_ptr <= '0;
    end else if (pop) begin
      rd_ptr <= rd_ptr + (AW+1)'(1);
    end
  end
endmodule
`default_nettype wire

// *** verif/host_cmd_decoder_chk.sv ***
// Port checker for the host command decoder
`timescale 1ns/100ps
`default_nettype none
module host_cmd_decoder_chk (
  // Clock, reset, stage
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        FRAMEWORK_MODE,
  // Command stream
  input wire logic        CMD_VALID,
  input wire logic        CMD_READY,
  input wire logic [7:0]  CMD_DATA,
  // Decoded command
  input wire logic        DEC_VALID,
  input wire logic [15:0] DEC_ID,
  input wire logic [2:0]  DEC_CLASS,
  input wire logic        DEC_STATUS_EXPECTED,
  input wire logic        PAY_VALID,
  input wire logic [7:0]  PAY_DATA,
  // Status stream
  input wire logic        STAT_VALID,
  input wire logic [7:0]  STAT_DATA,
  input wire logic        STAT_READY
);
  default clocking cb @(posedge CLK); endclocking
  a_reset_idle: assert property (RST |=> !DEC_VALID && !STAT_VALID && CMD_READY)
    else $error("outputs busy after reset");
  a_dec_pulse: assert property (disable iff (RST) DEC_VALID |=> !DEC_VALID)
    else $error("decode strobe held");
  a_pay_echo: assert property (disable iff (RST) PAY_VALID |->
    $past(CMD_VALID && CMD_READY) && PAY_DATA == $past(CMD_DATA))
    else $error("payload byte not echoed");
  a_boot_ids: assert property (disable iff (RST) DEC_VALID && DEC_CLASS == 3'h2 |->
    DEC_ID inside {[16'h0002:16'h0006], 16'h0017} && !$past(FRAMEWORK_MODE))
    else $error("bad bootloader command");
  a_fw_ids: assert property (disable iff (RST) DEC_VALID && DEC_CLASS == 3'h3 |->
    DEC_ID inside {[16'h0007:16'h0012], 16'h0015} && $past(FRAMEWORK_MODE))
    else $error("bad framework command");
  a_param_wr: assert property (disable iff (RST) DEC_VALID && DEC_ID inside
    {[16'h0100:16'h0FFF]} |-> DEC_CLASS == 3'h4 && DEC_STATUS_EXPECTED)
    else $error("parameter write misdecoded");
  a_param_rd: assert property (disable iff (RST) DEC_VALID && DEC_ID inside
    {[16'h1000:16'h1FFF]} |-> DEC_CLASS == 3'h5 && DEC_STATUS_EXPECTED)
    else $error("parameter read misdecoded");
  a_status_set: assert property (disable iff (RST) DEC_VALID |-> DEC_STATUS_EXPECTED ==
    (DEC_ID inside {16'h0001, 16'h0004, 16'h0005, 16'h0007, [16'h000A:16'h000C],
    16'h0011, 16'h0012, 16'h0017} || DEC_ID >= 16'h0100))
    else $error("status expectation wrong");
  a_no_invalid: assert property (disable iff (RST) DEC_VALID |->
    DEC_CLASS inside {[3'h1:3'h5]})
    else $error("invalid command decoded");
  a_stat_hold: assert property (disable iff (RST) STAT_VALID && !STAT_READY |=>
    STAT_VALID && $stable(STAT_DATA))
    else $error("status byte dropped");
  c_param: cover property (DEC_VALID && DEC_CLASS == 3'h4);
  c_full: cover property (STAT_VALID && !STAT_READY && !CMD_READY);
  c_pay: cover property (PAY_VALID);
  c_dump: cover property (STAT_VALID && STAT_DATA == 8'h03 && !CMD_READY);
  c_error: cover property (STAT_VALID && STAT_DATA == 8'h10 && !CMD_READY);
endmodule
bind host_cmd_decoder host_cmd_decoder_chk host_cmd_decoder_chk_i (
  .CLK(CLK), .RST(RST), .FRAMEWORK_MODE(FRAMEWORK_MODE),
  .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .CMD_DATA(CMD_DATA),
  .DEC_VALID(DEC_VALID), .DEC_ID(DEC_ID), .DEC_CLASS(DEC_CLASS),
  .DEC_STATUS_EXPECTED(DEC_STATUS_EXPECTED), .PAY_VALID(PAY_VALID), .PAY_DATA(PAY_DATA),
  .STAT_VALID(STAT_VALID), .STAT_DATA(STAT_DATA), .STAT_READY(STAT_READY)
);
`default_nettype wire

// *** verif/host_cmd_host.sv ***
// Host processor model: sends command bytes, drains status bytes
`timescale 1ns/100ps
`default_nettype none
module host_cmd_host (
  // Clock
  input wire logic        clk,
  // Command stream
  output logic            cmd_valid,
  output logic      [7:0] cmd_data,
  input  wire logic       cmd_ready,
  // Status stream
  input  wire logic       stat_valid,
  input  wire logic [7:0] stat_data,
  output logic            stat_ready
);
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];
  logic       stall = 1'b0;
  initial begin
    cmd_valid = 1'b0;
    cmd_data = 8'h00;
    stat_ready = 1'b0;
  end
  // Byte leaves only on an accepted edge
  always @(posedge clk) begin
    if (cmd_valid && cmd_ready) void'(tx_q.pop_front());
    if (stat_valid && stat_ready) rx_q.push_back(stat_data);
  end
  // Idle data toggles so a stale byte never looks valid
  always @(negedge clk) begin
    cmd_valid <= (tx_q.size() != 0);
    cmd_data <= (tx_q.size() != 0) ? tx_q[0] : ~cmd_data;
    stat_ready <= !stall;
  end
endmodule
`default_nettype wire

// *** verif/host_cmd_decoder_bench.sv ***
// Self-checking bench for the host command decoder
`timescale 1ns/100ps
`default_nettype none
module host_cmd_decoder_bench;
  logic        clk, rst, fw, cv, cr, dv, ds, pv, sv, sr, we;
  logic [7:0]  cd, sd, pd;
  logic [15:0] di, dl;
  logic [2:0]  dc;
  logic [6:0]  wa;
  logic [31:0] wd;
  logic [7:0]  img[512];
  logic [7:0]  e[212];
  int          errors = 0, check_count = 0, ndec = 0, npay = 0;

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    ndec <= ndec + int'(dv);
    npay <= npay + int'(pv);
  end

  host_cmd_decoder host_cmd_decoder_i (
    .CLK(clk), .RST(rst), .FRAMEWORK_MODE(fw),
    .CMD_VALID(cv), .CMD_DATA(cd), .CMD_READY(cr),
    .DEC_VALID(dv), .DEC_ID(di), .DEC_LENGTH(dl), .DEC_CLASS(dc),
    .DEC_STATUS_EXPECTED(ds), .PAY_VALID(pv), .PAY_DATA(pd),
    .DUMP_WE(we), .DUMP_WADDR(wa), .DUMP_WDATA(wd),
    .STAT_VALID(sv), .STAT_DATA(sd), .STAT_READY(sr)
  );
  host_cmd_host host_cmd_host_i (
    .clk(clk), .cmd_valid(cv), .cmd_data(cd), .cmd_ready(cr),
    .stat_valid(sv), .stat_data(sd), .stat_ready(sr)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic wait_q(input bit tx, input int n);
    int t;
    t = 0;
    while (tx ? host_cmd_host_i.tx_q.size() != 0 : host_cmd_host_i.rx_q.size() < n) begin
      @(posedge clk);
      t++;
      if (t > 5000) begin
        errors++;
        give_verdict();
      end
    end
  endtask

  function automatic logic [2:0] cls_exp(input logic [15:0] id);
    if (!fw && ((id >= 16'h0002 && id <= 16'h0006) || id == 16'h0017)) return 3'h2;
    if (fw && ((id >= 16'h0007 && id <= 16'h0012) || id == 16'h0015)) return 3'h3;
    if (fw && id >= 16'h0100 && id <= 16'h0FFF) return 3'h4;
    if (fw && id >= 16'h1000 && id <= 16'h1FFF) return 3'h5;
    return 3'h0;
  endfunction

  function automatic logic [31:0] crc(input int a, input int b);
    logic [31:0] c;
    c = 32'hFFFF_FFFF;
    for (int i = a; i <= b; i++) begin
      c = c ^ {24'h0, e[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 32'hEDB8_8320 : c >> 1;
    end
    return ~c;
  endfunction

  task automatic send(input logic [15:0] id, input logic [15:0] len, input int np);
    int k;
    @(posedge clk);
    host_cmd_host_i.tx_q = {id[7:0], id[15:8], len[7:0], len[15:8]};
    for (k = 0; k < np; k++) host_cmd_host_i.tx_q.push_back(8'hA0 + 8'(k));
    wait_q(1'b1, 0);
    repeat (3) @(posedge clk);
  endtask

  task automatic run_cmd(input logic [15:0] id, input logic [15:0] len, input int np);
    int d0, p0, k;
    logic [2:0] c;
    logic [7:0] x[8];
    logic st;
    d0 = ndec;
    p0 = npay;
    c = cls_exp(id);
    st = id inside {16'h0004, 16'h0005, 16'h0007, 16'h000A, 16'h000B, 16'h000C,
      16'h0011, 16'h0012, 16'h0017} || id >= 16'h0100;
    send(id, len, np);
    if (c != 3'h0) begin
      chk(ndec - d0, 1);
      chk({di, dl}, {id, len});
      chk(dc, c);
      chk(ds, st);
      chk(npay - p0, np);
      if (np > 0) chk(pd, 8'hA0 + 8'(np - 1));
      chk(host_cmd_host_i.rx_q.size(), 0);
    end else begin
      chk(ndec - d0 + npay - p0, 0);
      wait_q(1'b0, 8);
      x = '{8'h10, 8'h00, 8'h04, 8'h00, id[7:0], id[15:8], 8'hC0, 8'h00};
      for (k = 0; k < 8; k++) chk(host_cmd_host_i.rx_q.pop_front(), x[k]);
    end
  endtask

  task automatic t_boot();
    int i;
    @(negedge clk);
    fw = 1'b0;
    for (i = 2; i <= 6; i++) run_cmd(16'(i), 16'h0000, 0);
    run_cmd(16'h0005, 16'h0003, 3);
    run_cmd(16'h0017, 16'h0002, 4);
    $display("test bootloader done");
  endtask

  task automatic t_frame();
    int i;
    logic [15:0] pr[4] = '{16'h0100, 16'h0FFF, 16'h1000, 16'h1FFF};
    @(negedge clk);
    fw = 1'b1;
    for (i = 7; i <= 18; i++) run_cmd(16'(i), 16'h0000, 0);
    run_cmd(16'h0015, 16'h0001, 1);
    foreach (pr[i]) run_cmd(pr[i], 16'h0002, 2);
    $display("test framework done");
  endtask

  task automatic t_bad();
    logic [15:0] bb[5] = '{16'h0007, 16'h0100, 16'h1000, 16'h0000, 16'h0013};
    logic [15:0] fb[6] = '{16'h0001, 16'h0002, 16'h0006, 16'h0016, 16'h00FF, 16'hFFFF};
    @(negedge clk);
    fw = 1'b0;
    foreach (bb[i]) run_cmd(bb[i], 16'h0000, 0);
    run_cmd(16'h2000, 16'h0003, 3);
    run_cmd(16'h0001, 16'h0002, 2);
    @(negedge clk);
    fw = 1'b1;
    foreach (fb[i]) run_cmd(fb[i], 16'h0000, 0);
    $display("test invalid done");
  endtask

  task automatic t_crash();
    int i;
    for (i = 0; i < 512; i++) img[i] = 8'(i) ^ 8'h5A;
    {img[135], img[134], img[133], img[132]} = 32'h0008_0401;
    {img[175], img[174], img[173]} = 24'h44_00_04;
    for (i = 0; i < 128; i++) begin
      @(negedge clk);
      we = 1'b1;
      wa = 7'(i);
      wd = {img[4*i+3], img[4*i+2], img[4*i+1], img[4*i]};
    end
    @(negedge clk);
    we = 1'b0;
    fw = 1'b0;
    {e[0], e[1], e[2], e[3]} = {8'h03, 8'h00, 8'hD0, 8'h00};
    for (i = 4; i < 212; i++) e[i] = (i >= 184 && i < 204) ? 8'h00 : img[i];
    {e[199], e[198], e[197], e[196]} = crc(204, 211);
    {e[203], e[202], e[201], e[200]} = crc(4, 199);
    host_cmd_host_i.stall = 1'b1;
    send(16'h0001, 16'h0000, 0);
    chk({dc, ds}, 4'h3);
    repeat (400) @(posedge clk);
    chk({sv, cr}, 2'b10);
    host_cmd_host_i.stall = 1'b0;
    wait_q(1'b0, 212);
    repeat (20) @(posedge clk);
    chk(host_cmd_host_i.rx_q.size(), 212);
    for (i = 0; i < 212; i++) chk(host_cmd_host_i.rx_q.pop_front(), e[i]);
    $display("test crash dump done");
  endtask

  initial begin
    rst = 1'b1;
    fw = 1'b0;
    we = 1'b0;
    wa = 7'h00;
    wd = 32'h0;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_boot();
    t_frame();
    t_bad();
    t_crash();
    give_verdict();
  end
endmodule
`default_nettype wire
